// *** rgc_config.sv ***
// Gain control configuration registers, carrier sense and gain loop top
`timescale 1ns/1ns
// What this block does
// - Digital gain ceiling code N forbids the top N digital gain steps.
// - Front amplifier ceiling code caps combined first and second amp gain.
// - Amplitude target code selects 24 to 42 dB loop target.
// - Order bit set lowers first amp first; clear empties second amp first.
// - Relative sense code selects off, 6, 10 or 14 dB RSSI rise.
// - Absolute sense threshold is signed dB above target; code 1000 disables.
module rgc_config
   import rgc_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic nrst_in,
   // Configuration port
   input wire logic [5:0] cfg_addr_in,
   input wire logic [7:0] cfg_wdata_in,
   input wire logic cfg_write_in,
   input wire logic cfg_read_in,
   output logic [7:0] cfg_rdata_out,
   output logic cfg_rvalid_out,
   // Measurements
   input wire logic amp_valid_in,
   input wire logic [7:0] amp_db_in,
   input wire logic rssi_valid_in,
   input wire logic [7:0] rssi_db_in,
   // Gain and sense state
   output logic [2:0] digital_gain_step_out,
   output logic [1:0] first_amp_red_out,
   output logic [2:0] second_amp_red_out,
   output logic carrier_sense_out
);
   import rgc_pkg::*;

   logic [7:0] gain_limits_and_target;
   logic [7:0] gain_priority_and_carrier_sense;
   logic [7:0] next_limits;
   logic [7:0] next_prio;
   logic [7:0] next_rdata;
   logic next_rvalid;
   // Carrier sense state
   logic abs_hit;
   logic rel_hit;
   logic [7:0] rssi_ref;
   logic next_abs_hit;
   logic next_rel_hit;
   logic [7:0] next_rssi_ref;
   logic next_sense;
   logic [7:0] target_db;
   logic [7:0] rel_db;

   // Named register fields
   logic [1:0] digital_gain_ceiling;
   logic [2:0] front_amp_gain_ceiling;
   logic [2:0] amplitude_target;
   logic stage_reduction_order;
   logic [1:0] relative_sense_threshold;
   logic [3:0] absolute_sense_threshold;
   logic limits_sel;
   logic prio_sel;

   // Target code to dB
   function automatic logic [7:0] rgc_target_db(input logic [2:0] code);
      case (code)
         3'h0: rgc_target_db = RGC_TARGET_DB0;
         3'h1: rgc_target_db = RGC_TARGET_DB1;
         3'h2: rgc_target_db = RGC_TARGET_DB2;
         3'h3: rgc_target_db = RGC_TARGET_DB3;
         3'h4: rgc_target_db = RGC_TARGET_DB4;
         3'h5: rgc_target_db = RGC_TARGET_DB5;
         3'h6: rgc_target_db = RGC_TARGET_DB6;
         default: rgc_target_db = RGC_TARGET_DB7;
      endcase
   endfunction

   // Relative code to dB rise, zero meaning off
   function automatic logic [7:0] rgc_rel_db(input logic [1:0] code);
      case (code)
         2'h1: rgc_rel_db = RGC_REL_DB1;
         2'h2: rgc_rel_db = RGC_REL_DB2;
         2'h3: rgc_rel_db = RGC_REL_DB3;
         default: rgc_rel_db = 8'h00;
      endcase
   endfunction

   assign digital_gain_ceiling = gain_limits_and_target[RGC_DIG_CEIL_LSB +: 2];
   assign front_amp_gain_ceiling = gain_limits_and_target[RGC_FRONT_CEIL_LSB +: 3];
   assign amplitude_target = gain_limits_and_target[RGC_TARGET_LSB +: 3];
   assign stage_reduction_order = gain_priority_and_carrier_sense[RGC_ORDER_BIT];
   assign relative_sense_threshold = gain_priority_and_carrier_sense[RGC_REL_THR_LSB +: 2];
   assign absolute_sense_threshold = gain_priority_and_carrier_sense[RGC_ABS_THR_LSB +: 4];

   // Address match, shared by the write and read paths
   assign limits_sel = (cfg_addr_in == RGC_ADDR_LIMITS);
   assign prio_sel = (cfg_addr_in == RGC_ADDR_PRIO);

   assign target_db = rgc_target_db(amplitude_target);
   assign rel_db = rgc_rel_db(relative_sense_threshold);

   // Register storage; a write lands at the edge that takes it
   always_comb begin
      next_limits = gain_limits_and_target;
      next_prio = gain_priority_and_carrier_sense;
      if (cfg_write_in && limits_sel) begin
         next_limits = cfg_wdata_in;
      end
      // Unused top bit stays zero
      if (cfg_write_in && prio_sel) begin
         next_prio = cfg_wdata_in & RGC_PRIO_RW_MASK;
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         gain_limits_and_target <= RGC_LIMITS_RESET;
         gain_priority_and_carrier_sense <= RGC_PRIO_RESET;
      end else begin
         gain_limits_and_target <= next_limits;
         gain_priority_and_carrier_sense <= next_prio;
      end
   end

   // Readback shows old contents when a write lands in the same cycle
   always_comb begin
      // Read data holds until the next read
      next_rdata = cfg_rdata_out;
      next_rvalid = 1'b0;
      if (cfg_read_in) begin
         next_rvalid = 1'b1;
         if (limits_sel) begin
            next_rdata = gain_limits_and_target;
         end else if (prio_sel) begin
            next_rdata = gain_priority_and_carrier_sense;
         end else begin
            // Unmapped addresses read as zero
            next_rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cfg_rdata_out <= 8'h00;
         cfg_rvalid_out <= 1'b0;
      end else begin
         cfg_rdata_out <= next_rdata;
         cfg_rvalid_out <= next_rvalid;
      end
   end

   // Carrier sense detectors
   always_comb begin
      logic signed [9:0] abs_level;
      logic [3:0] abs_code;
      logic [8:0] ref_plus;
      abs_code = absolute_sense_threshold;
      // Sign-extended code added to the loop target
      abs_level = $signed({2'b00, target_db}) + $signed({{6{abs_code[3]}}, abs_code});
      ref_plus = {1'b0, rssi_ref} + {1'b0, rel_db};
      next_abs_hit = abs_hit;
      next_rel_hit = rel_hit;
      next_rssi_ref = rssi_ref;
      if (abs_code == RGC_ABS_DISABLE) begin
         next_abs_hit = 1'b0;
      end else if (amp_valid_in) begin
         next_abs_hit = $signed({2'b00, amp_db_in}) >= abs_level;
      end
      if (rel_db == 8'h00) begin
         // Disabled: reference keeps tracking for a clean start
         next_rel_hit = 1'b0;
         if (rssi_valid_in) begin
            next_rssi_ref = rssi_db_in;
         end
      end else if (rssi_valid_in) begin
         next_rel_hit = {1'b0, rssi_db_in} >= ref_plus;
         // Reference holds while sensing so a slow fade does not drop it
         if (!next_rel_hit) begin
            next_rssi_ref = rssi_db_in;
         end
      end
      // Either detector raises sense
      next_sense = next_abs_hit | next_rel_hit;
   end

   // Sense comes from a flop, one cycle after the sample
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         abs_hit <= 1'b0;
         rel_hit <= 1'b0;
         rssi_ref <= 8'h00;
         carrier_sense_out <= 1'b0;
      end else begin
         abs_hit <= next_abs_hit;
         rel_hit <= next_rel_hit;
         rssi_ref <= next_rssi_ref;
         carrier_sense_out <= next_sense;
      end
   end

   // ceilings read live at each decision
   rgc_gain_ctrl u_gain (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .decide_in(amp_valid_in),
      .amp_db_in(amp_db_in),
      .target_db_in(target_db),
      .dig_ceiling_in(digital_gain_ceiling),
      .front_ceiling_in(front_amp_gain_ceiling),
      .first_priority_in(stage_reduction_order),
      .digital_gain_step_out(digital_gain_step_out),
      .first_amp_red_out(first_amp_red_out),
      .second_amp_red_out(second_amp_red_out)
   );
endmodule

// *** rgc_config_checker.sv ***
// Concurrent checks on the ports of the gain control configuration top
`timescale 1ns/1ns
module rgc_config_checker
   import rgc_pkg::*;
(
   // Clock, reset and configuration port
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic [5:0] cfg_addr_in,
   input wire logic [7:0] cfg_wdata_in,
   input wire logic cfg_write_in,
   input wire logic cfg_read_in,
   input wire logic [7:0] cfg_rdata_out,
   input wire logic cfg_rvalid_out,
   // Measurements and gain state
   input wire logic amp_valid_in,
   input wire logic [7:0] amp_db_in,
   input wire logic rssi_valid_in,
   input wire logic [7:0] rssi_db_in,
   input wire logic [2:0] digital_gain_step_out,
   input wire logic [1:0] first_amp_red_out,
   input wire logic [2:0] second_amp_red_out,
   input wire logic carrier_sense_out
);
   localparam logic [7:0] TGT [8] = '{RGC_TARGET_DB0, RGC_TARGET_DB1, RGC_TARGET_DB2,
      RGC_TARGET_DB3, RGC_TARGET_DB4, RGC_TARGET_DB5, RGC_TARGET_DB6, RGC_TARGET_DB7};
   // Shadows of both registers, so ceilings are known from the ports alone
   logic [7:0] lim;
   logic [7:0] prio;
   logic [8:0] abs_lvl;
   logic [3:0] front_sum;
   logic [2:0] dig_cap;
   logic [2:0] front_cap;
   assign abs_lvl = {1'b0, TGT[lim[2:0]]} + {{5{prio[3]}}, prio[3:0]};
   assign front_sum = {2'b00, first_amp_red_out} + {1'b0, second_amp_red_out};
   assign dig_cap = 3'h7 - {1'b0, lim[7:6]};
   assign front_cap = lim[5:3];
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lim <= RGC_LIMITS_RESET;
         prio <= RGC_PRIO_RESET;
      end else if (cfg_write_in && cfg_addr_in == RGC_ADDR_LIMITS) begin
         lim <= cfg_wdata_in;
      end else if (cfg_write_in && cfg_addr_in == RGC_ADDR_PRIO) begin
         prio <= cfg_wdata_in & RGC_PRIO_RW_MASK;
      end
   end
   chk_limits_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
      cfg_read_in && cfg_addr_in == RGC_ADDR_LIMITS |=> cfg_rvalid_out && cfg_rdata_out == $past(lim))
      else $error("limits readback wrong");
   chk_prio_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
      cfg_read_in && cfg_addr_in == RGC_ADDR_PRIO |=> cfg_rvalid_out && cfg_rdata_out == $past(prio))
      else $error("priority readback wrong");
   chk_dig_ceiling: assert property (@(posedge clock_in) disable iff (!nrst_in)
      amp_valid_in |=> digital_gain_step_out <= $past(dig_cap))
      else $error("digital step above ceiling");
   chk_front_ceiling: assert property (@(posedge clock_in) disable iff (!nrst_in)
      amp_valid_in |=> front_sum >= {1'b0, $past(front_cap)})
      else $error("front gain above ceiling");
   chk_gain_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
      !amp_valid_in |=> $stable({digital_gain_step_out, first_amp_red_out, second_amp_red_out}))
      else $error("gain moved without decision");
   chk_first_order: assert property (@(posedge clock_in) disable iff (!nrst_in)
      amp_valid_in && prio[6] && front_cap == 3'h0 && front_sum == 4'h0 |=> second_amp_red_out == 3'h0)
      else $error("second amp cut before first");
   chk_second_order: assert property (@(posedge clock_in) disable iff (!nrst_in)
      amp_valid_in && !prio[6] && front_cap == 3'h0 && front_sum == 4'h0 |=> first_amp_red_out == 2'h0)
      else $error("first amp cut before second");
   chk_abs_level: assert property (@(posedge clock_in) disable iff (!nrst_in)
      amp_valid_in && !rssi_valid_in && prio[5:4] == 2'h0 && prio[3:0] != RGC_ABS_DISABLE
      |=> carrier_sense_out == ({1'b0, $past(amp_db_in)} >= $past(abs_lvl))) else $error("abs sense wrong");
endmodule
bind rgc_config rgc_config_checker u_chk (.clock_in(clock_in), .nrst_in(nrst_in),
   .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in), .cfg_write_in(cfg_write_in),
   .cfg_read_in(cfg_read_in), .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out),
   .amp_valid_in(amp_valid_in), .amp_db_in(amp_db_in), .rssi_valid_in(rssi_valid_in),
   .rssi_db_in(rssi_db_in), .digital_gain_step_out(digital_gain_step_out),
   .first_amp_red_out(first_amp_red_out), .second_amp_red_out(second_amp_red_out),
   .carrier_sense_out(carrier_sense_out));

// *** rgc_gain_ctrl.sv ***
// Gain step decision logic bounded by the two gain ceilings
`timescale 1ns/1ns
module rgc_gain_ctrl
   import rgc_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic nrst_in,
   // Decision request
   input wire logic decide_in,
   input wire logic [7:0] amp_db_in,
   input wire logic [7:0] target_db_in,
   // Ceilings and order
   input wire logic [1:0] dig_ceiling_in,
   input wire logic [2:0] front_ceiling_in,
   input wire logic first_priority_in,
   // Gain state
   output logic [2:0] digital_gain_step_out,
   output logic [1:0] first_amp_red_out,
   output logic [2:0] second_amp_red_out
);
   import rgc_pkg::*;

   logic [2:0] next_dig;
   logic [1:0] next_first;
   logic [2:0] next_second;

   // Adds up to amount steps of front reduction in the chosen order
   function automatic logic [4:0] rgc_reduce(input logic [1:0] f, input logic [2:0] s,
                                             input logic [2:0] amount, input logic prio);
      logic [1:0] ff;
      logic [2:0] ss;
      ff = f;
      ss = s;
      for (int i = 0; i < 7; i++) begin
         if (i < int'(amount)) begin
            if (prio) begin
               if (ff < RGC_FIRST_RED_MAX) ff = ff + 2'h1;
               else if (ss < RGC_SECOND_RED_MAX) ss = ss + 3'h1;
            end else begin
               if (ss < RGC_SECOND_RED_MAX) ss = ss + 3'h1;
               else if (ff < RGC_FIRST_RED_MAX) ff = ff + 2'h1;
            end
         end
      end
      return {ff, ss};
   endfunction

   always_comb begin
      logic [2:0] max_dig;
      logic [2:0] total;
      logic [2:0] d;
      logic [1:0] f;
      logic [2:0] s;
      max_dig = RGC_DIG_STEP_MAX - {1'b0, dig_ceiling_in};
      d = digital_gain_step_out;
      f = first_amp_red_out;
      s = second_amp_red_out;
      total = 3'h0;
      next_dig = d;
      next_first = f;
      next_second = s;
      if (decide_in) begin
         if (d > max_dig) d = max_dig;
         total = {1'b0, f} + s;
         if (total < front_ceiling_in) begin
            {f, s} = rgc_reduce(f, s, front_ceiling_in - total, first_priority_in);
         end
         total = {1'b0, f} + s;
         if (amp_db_in > target_db_in) begin
            if (total < 3'h7) {f, s} = rgc_reduce(f, s, 3'h1, first_priority_in);
            else if (d != 3'h0) d = d - 3'h1;
         end else if (amp_db_in < target_db_in) begin
            if (d < max_dig) begin
               d = d + 3'h1;
            end else if (total > front_ceiling_in) begin
               // Undo in reverse of reduction order
               if (first_priority_in) begin
                  if (s != 3'h0) s = s - 3'h1;
                  else f = f - 2'h1;
               end else begin
                  if (f != 2'h0) f = f - 2'h1;
                  else s = s - 3'h1;
               end
            end
         end
         next_dig = d;
         next_first = f;
         next_second = s;
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         digital_gain_step_out <= RGC_DIG_STEP_RESET;
         first_amp_red_out <= RGC_FIRST_RED_RESET;
         second_amp_red_out <= RGC_SECOND_RED_RESET;
      end else begin
         digital_gain_step_out <= next_dig;
         first_amp_red_out <= next_first;
         second_amp_red_out <= next_second;
      end
   end
endmodule

// *** rgc_pkg.sv ***
// Constants shared by the receive gain control configuration slice
package rgc_pkg;
   // Register offsets on the configuration port
   localparam logic [5:0] RGC_ADDR_LIMITS = 6'h1B;
   localparam logic [5:0] RGC_ADDR_PRIO = 6'h1C;
   // Values after reset
   localparam logic [7:0] RGC_LIMITS_RESET = 8'h03;
   localparam logic [7:0] RGC_PRIO_RESET = 8'h40;
   // Field positions, limits register
   localparam int RGC_DIG_CEIL_LSB = 6;
   localparam int RGC_FRONT_CEIL_LSB = 3;
   localparam int RGC_TARGET_LSB = 0;
   // Field positions, priority register
   localparam int RGC_ORDER_BIT = 6;
   localparam int RGC_REL_THR_LSB = 4;
   localparam int RGC_ABS_THR_LSB = 0;
   localparam logic [7:0] RGC_PRIO_RW_MASK = 8'h7F;
   // Absolute threshold code that disables the absolute detector
   localparam logic [3:0] RGC_ABS_DISABLE = 4'h8;
   // Gain stage step ranges
   localparam logic [2:0] RGC_DIG_STEP_MAX = 3'h7;
   localparam logic [1:0] RGC_FIRST_RED_MAX = 2'h3;
   localparam logic [2:0] RGC_SECOND_RED_MAX = 3'h4;
   // Gain state after reset: full gain everywhere
   localparam logic [2:0] RGC_DIG_STEP_RESET = 3'h7;
   localparam logic [1:0] RGC_FIRST_RED_RESET = 2'h0;
   localparam logic [2:0] RGC_SECOND_RED_RESET = 3'h0;
   // Amplitude targets in dB, by code
   localparam logic [7:0] RGC_TARGET_DB0 = 8'h18;
   localparam logic [7:0] RGC_TARGET_DB1 = 8'h1B;
   localparam logic [7:0] RGC_TARGET_DB2 = 8'h1E;
   localparam logic [7:0] RGC_TARGET_DB3 = 8'h21;
   localparam logic [7:0] RGC_TARGET_DB4 = 8'h24;
   localparam logic [7:0] RGC_TARGET_DB5 = 8'h26;
   localparam logic [7:0] RGC_TARGET_DB6 = 8'h28;
   localparam logic [7:0] RGC_TARGET_DB7 = 8'h2A;
   // Relative carrier-sense rises in dB, by code
   localparam logic [7:0] RGC_REL_DB1 = 8'h06;
   localparam logic [7:0] RGC_REL_DB2 = 8'h0A;
   localparam logic [7:0] RGC_REL_DB3 = 8'h0E;
endpackage

// *** testbench.sv ***
// Self-checking bench for the gain control configuration top
`timescale 1ns/1ns
module testbench;
   import rgc_pkg::*;
   logic clk = 0, nrst = 0, wr = 0, rd = 0, av = 0, rv = 0, rval, cs;
   logic [5:0] addr = 0;
   logic [7:0] wdat = 0, amp = 0, rssi = 0, rdat;
   logic [2:0] dig, sec;
   logic [1:0] fst;
   int bad_count = 0, checks_done = 0;
   localparam logic [7:0] TGT [8] = '{RGC_TARGET_DB0, RGC_TARGET_DB1, RGC_TARGET_DB2,
      RGC_TARGET_DB3, RGC_TARGET_DB4, RGC_TARGET_DB5, RGC_TARGET_DB6, RGC_TARGET_DB7};
   rgc_config u_dut (.clock_in(clk), .nrst_in(nrst), .cfg_addr_in(addr), .cfg_wdata_in(wdat),
      .cfg_write_in(wr), .cfg_read_in(rd), .cfg_rdata_out(rdat), .cfg_rvalid_out(rval),
      .amp_valid_in(av), .amp_db_in(amp), .rssi_valid_in(rv), .rssi_db_in(rssi),
      .digital_gain_step_out(dig), .first_amp_red_out(fst), .second_amp_red_out(sec),
      .carrier_sense_out(cs));
   initial forever #20 clk = ~clk;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks=%0d bad=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic rst;
      nrst = 0;
      repeat (4) @(negedge clk);
      nrst = 1;
   endtask
   task automatic wreg(input logic [5:0] a, input logic [7:0] d);
      @(negedge clk);
      {addr, wdat, wr} = {a, d, 1'b1};
      @(negedge clk);
      wr = 0;
   endtask
   // Read answer stands one cycle, so it is sampled right then
   task automatic rreg(input logic [5:0] a, input logic [7:0] e);
      @(negedge clk);
      {addr, rd} = {a, 1'b1};
      @(negedge clk);
      rd = 0;
      chk(8'(rval), 8'h01);
      chk(rdat, e);
   endtask
   task automatic samp(input logic is_amp, input logic [7:0] d);
      @(negedge clk);
      if (is_amp) {av, amp} = {1'b1, d};
      else {rv, rssi} = {1'b1, d};
      @(negedge clk);
      {av, rv} = 2'b00;
      @(negedge clk);
   endtask
   task automatic t_regs;
      rst();
      rreg(RGC_ADDR_LIMITS, RGC_LIMITS_RESET);
      rreg(RGC_ADDR_PRIO, RGC_PRIO_RESET);
      chk({dig, fst, sec}, 8'hE0);
      wreg(RGC_ADDR_LIMITS, 8'hFF);
      wreg(RGC_ADDR_PRIO, 8'hFF);
      wreg(6'h1D, 8'h55);
      rreg(RGC_ADDR_LIMITS, 8'hFF);
      rreg(RGC_ADDR_PRIO, 8'h7F);
      rreg(6'h1D, 8'h00);
      $display("t_regs done");
   endtask
   // Ceiling code stepped down from 3 to 0; code 3 clamps gain from 7 to 4, then low input lifts it to each new ceiling
   task automatic t_dig;
      rst();
      for (int c = 3; c >= 0; c--) begin
         wreg(RGC_ADDR_LIMITS, 8'((c << 6) | 3));
         samp(1'b1, 8'h00);
         chk({dig, fst, sec}, {3'(7 - c), 5'h00});
      end
      $display("t_dig done");
   endtask
   task automatic t_order(input logic p);
      int fx;
      rst();
      wreg(RGC_ADDR_PRIO, {1'b0, p, 6'h00});
      samp(1'b1, 8'hFF);
      chk({3'h0, fst, sec}, p ? 8'h08 : 8'h01);
      for (int f = 0; f < 8; f++) begin
         wreg(RGC_ADDR_LIMITS, 8'((f << 3) | 3));
         samp(1'b1, 8'h00);
         fx = p ? (f > 3 ? 3 : f) : (f > 4 ? f - 4 : 0);
         chk({3'h0, fst, sec}, 8'((fx << 3) | (f - fx)));
      end
      samp(1'b1, 8'hFF);
      chk({5'h00, dig}, 8'h06);
      $display("t_order done");
   endtask
   task automatic t_abs;
      logic [3:0] code [3] = '{4'h0, 4'h7, 4'h9};
      logic [7:0] lvl;
      rst();
      for (int k = 0; k < 8; k++) begin
         wreg(RGC_ADDR_LIMITS, 8'(k));
         for (int j = 0; j < 3; j++) begin
            wreg(RGC_ADDR_PRIO, {4'h4, code[j]});
            lvl = TGT[k] + {{4{code[j][3]}}, code[j]};
            samp(1'b1, lvl);
            chk(8'(cs), 8'h01);
            samp(1'b1, lvl - 8'h01);
            chk(8'(cs), 8'h00);
         end
      end
      wreg(RGC_ADDR_PRIO, {4'h4, RGC_ABS_DISABLE});
      samp(1'b1, 8'hFF);
      chk(8'(cs), 8'h00);
      $display("t_abs done");
   endtask
   // Two quiet samples first, so a frozen reference cannot leak across codes
   task automatic t_rel;
      logic [7:0] rise [4] = '{8'h00, RGC_REL_DB1, RGC_REL_DB2, RGC_REL_DB3};
      for (int r = 0; r < 4; r++) begin
         wreg(RGC_ADDR_PRIO, 8'(8'h48 | (r << 4)));
         repeat (2) samp(1'b0, 8'h00);
         samp(1'b0, rise[r] - 8'h01);
         chk(8'(cs), 8'h00);
         samp(1'b0, rise[r] + rise[r] - 8'h01);
         chk(8'(cs), 8'(r != 0));
      end
      $display("t_rel done");
   endtask
   initial begin
      t_regs();
      t_dig();
      t_order(1'b1);
      t_order(1'b0);
      t_abs();
      t_rel();
      give_verdict();
   end
   // Whole run is under five hundred cycles; allow five times that
   initial begin
      #100000;
      bad_count++;
      give_verdict();
   end
endmodule
